//--- design/adr_diag_record.sv
// How it works
// - Record set 01h returns whole record; record set 00h returns first four bytes.
// - CANopen index 2F01h returns whole record; 2F00h returns first four bytes.
// - EtherCAT index 5005h: one subindex per field, summary 02h, timestamp 13h.
// - Summary bits 0..3: module failure, internal, external, any channel error.
// - Summary bit 4 aux supply missing, bit 7 parameter error, bits 6:5 zero.
// - Module info bits 3:0 hold class 0101b analog; bits 7:5 read zero.
// - Module info bit 4 set with channel info present; reads 15h.
// - Channel count at subindex 08h reads 02h; channel bytes default 00h.
// - Channel 0/1 bytes at subindex 0Ah/0Bh; channels 2..7 read zero.
// - Extended byte: bit3 buffer overflow, bit4 comm error, bit6 interrupt lost.
// - Group byte: bit0 group 0 error, bit1 group 1 error, rest zero.
// - Channel byte: bit0 config error, bit5 interrupt lost, bits 4:1 zero.
// - Channel byte: bit6 range underflow, bit7 range overflow.
`timescale 1ns/1ps
`default_nettype none
module adr_diag_record
  import adr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic module_failure,
  input wire logic internal_error,
  input wire logic external_error,
  input wire logic aux_supply_missing,
  input wire logic param_error,
  input wire logic diag_buffer_overflow,
  input wire logic internal_comm_error,
  input wire logic process_irq_lost,
  input wire logic [1:0] ch_config_error,
  input wire logic [1:0] ch_irq_lost,
  input wire logic [1:0] ch_range_under,
  input wire logic [1:0] ch_range_over,
  input wire logic build_record,
  input wire logic rd_req,
  input wire logic [2:0] rd_path,
  input wire logic [7:0] record_set_number,
  input wire logic [15:0] object_index_number,
  input wire logic [7:0] object_subindex_number,
  input wire logic [7:0] rd_offset,
  output logic rd_valid,
  output logic rd_error,
  output logic [7:0] rd_data,
  output logic [7:0] rd_len
);

  // Snapshot registers, refreshed on build_record
  logic [7:0] summary_q, summary_d;
  logic [7:0] ext_q, ext_d;
  logic [7:0] group_q, group_d;
  logic [7:0] ch0_q, ch0_d;
  logic [7:0] ch1_q, ch1_d;
  logic [31:0] ts_q;
  logic [31:0] us_count_q;
  logic [7:0] div_q;
  logic rd_valid_q;
  logic rd_error_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_len_q;

  // Per-channel byte layout, reserved bits forced low
  function automatic logic [7:0] chan_byte(input logic cfg, input logic pil,
                                           input logic und, input logic ovr);
    logic [7:0] b;
    b = 8'h00;
    b[CH_CFG] = cfg;
    b[CH_PILOST] = pil;
    b[CH_UNDER] = und;
    b[CH_OVER] = ovr;
    return b;
  endfunction

  wire logic [7:0] class_byte = {3'b000, 1'b1, CLASS_ANALOG};
  wire logic [1:0] grp_err = {|chan_byte(ch_config_error[1], ch_irq_lost[1],
                               ch_range_under[1], ch_range_over[1]),
                              |chan_byte(ch_config_error[0], ch_irq_lost[0],
                               ch_range_under[0], ch_range_over[0])};

  // Next snapshot values from live error inputs
  always_comb
  begin
    summary_d = 8'h00;
    summary_d[SUM_FAIL] = module_failure;
    summary_d[SUM_INT] = internal_error;
    summary_d[SUM_EXT] = external_error;
    summary_d[SUM_CHAN] = |grp_err;
    summary_d[SUM_AUX] = aux_supply_missing;
    summary_d[SUM_PARM] = param_error;
    ext_d = 8'h00;
    ext_d[EXT_OVF] = diag_buffer_overflow;
    ext_d[EXT_COMM] = internal_comm_error;
    ext_d[EXT_PILOST] = process_irq_lost;
    group_d = {6'b000000, grp_err};
    ch0_d = chan_byte(ch_config_error[0], ch_irq_lost[0],
                      ch_range_under[0], ch_range_over[0]);
    ch1_d = chan_byte(ch_config_error[1], ch_irq_lost[1],
                      ch_range_under[1], ch_range_over[1]);
  end

  // Free-running microsecond ticker, wraps after 2^32-1
  wire logic us_tick = (div_q == US_CYCLES - 8'h01);
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      div_q <= 8'h00;
      us_count_q <= 32'h0000_0000;
    end
    else
    begin
      div_q <= us_tick ? 8'h00 : div_q + 8'h01;
      if (us_tick)
        us_count_q <= us_count_q + 32'h0000_0001;
    end
  end

  // Snapshot capture; timestamp taken with the record
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      summary_q <= 8'h00;
      ext_q <= 8'h00;
      group_q <= 8'h00;
      ch0_q <= 8'h00;
      ch1_q <= 8'h00;
      ts_q <= 32'h0000_0000;
    end
    else if (build_record)
    begin
      summary_q <= summary_d;
      ext_q <= ext_d;
      group_q <= group_d;
      ch0_q <= ch0_d;
      ch1_q <= ch1_d;
      ts_q <= us_count_q;
    end
  end

  // Byte at a record offset; unused channels and spare read zero
  function automatic logic [7:0] rec_byte(input logic [7:0] ofs,
                                          input logic [7:0] s, input logic [7:0] c,
                                          input logic [7:0] e, input logic [7:0] g,
                                          input logic [7:0] a, input logic [7:0] b,
                                          input logic [31:0] t);
    logic [7:0] r;
    r = 8'h00;
    if (ofs == OFS_SUMMARY) r = s;
    else if (ofs == OFS_CLASS) r = c;
    else if (ofs == OFS_EXT) r = e;
    else if (ofs == OFS_KIND) r = KIND_RESET;
    else if (ofs == OFS_BITS) r = BITS_RESET;
    else if (ofs == OFS_COUNT) r = COUNT_RESET;
    else if (ofs == OFS_GROUP) r = g;
    else if (ofs == OFS_CH0) r = a;
    else if (ofs == OFS_CH1) r = b;
    else if (ofs >= OFS_TS && ofs < OFS_TS + 8'h04) r = t[8*ofs[1:0] +: 8];
    return r;
  endfunction

  // Path decode: full or short record, or subindex to offset
  wire logic sel_full = (rd_path == ADR_PATH_REC && record_set_number == RECSET_FULL)
                     || (rd_path == ADR_PATH_IDX && object_index_number == IDX_FULL);
  wire logic sel_short = (rd_path == ADR_PATH_REC && record_set_number == RECSET_SHORT)
                      || (rd_path == ADR_PATH_IDX && object_index_number == IDX_SHORT);
  wire logic sel_sub = (rd_path == ADR_PATH_SUB) && (object_index_number == IDX_ECAT)
                    && (object_subindex_number >= SUB_SUMMARY)
                    && (object_subindex_number <= SUB_TS)
                    && (object_subindex_number != SUB_TS - 8'h01);
  wire logic sub_ts = (object_subindex_number == SUB_TS);
  wire logic sub_rsvd = (object_subindex_number >= SUB_CH2)
                     && (object_subindex_number <= SUB_CH7);
  wire logic [7:0] sub_ofs = sub_ts ? OFS_TS + {6'b000000, rd_offset[1:0]}
                                    : object_subindex_number - SUB_SUMMARY;
  wire logic [7:0] sub_len = sub_ts ? 8'h04 : (sub_rsvd ? 8'h06 : 8'h01);
  wire logic [7:0] eff_ofs = sel_sub ? sub_ofs : rd_offset;
  wire logic [7:0] eff_len = sel_full ? 8'(REC_LEN) : (sel_short ? 8'(SHORT_LEN) : sub_len);
  wire logic in_range = (sel_full && rd_offset < 8'(REC_LEN))
                     || (sel_short && rd_offset < 8'(SHORT_LEN))
                     || (sel_sub && (rd_offset < sub_len));
  wire logic [7:0] rsvd_fix = (sel_sub && sub_rsvd) ? 8'h00 : eff_ofs;
  wire logic [7:0] byte_out = rec_byte(rsvd_fix, summary_q, class_byte, ext_q, group_q,
                                       ch0_q, ch1_q, ts_q);

  // Read answer, one cycle after the request
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rd_valid_q <= 1'b0;
      rd_error_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_len_q <= 8'h00;
    end
    else
    begin
      rd_valid_q <= rd_req && in_range;
      rd_error_q <= rd_req && !in_range;
      if (rd_req)
      begin
        rd_data_q <= in_range ? ((sel_sub && sub_rsvd) ? 8'h00 : byte_out) : 8'h00;
        rd_len_q <= in_range ? eff_len : 8'h00;
      end
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_error = rd_error_q;
  assign rd_data = rd_data_q;
  assign rd_len = rd_len_q;

  // Checks
  summary_chan_a: assert property (@(posedge mclk) disable iff (!rst_n)
    summary_q[SUM_CHAN] == |group_q[1:0])
    else $error("summary channel bit disagrees with group errors");
  summary_rsvd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    summary_q[6:5] == 2'b00)
    else $error("summary reserved bits set");
  group_rsvd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    group_q[7:2] == 6'h00 && group_q[0] == |ch0_q && group_q[1] == |ch1_q)
    else $error("group byte inconsistent");
  chan_rsvd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ch0_q[4:1] == 4'h0 && ch1_q[4:1] == 4'h0)
    else $error("channel reserved bits set");
  ext_rsvd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ext_q[2:0] == 3'b000 && ext_q[5] == 1'b0 && ext_q[7] == 1'b0)
    else $error("extended reserved bits set");
  class_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_req && sel_full && rd_offset == OFS_CLASS) |=> (rd_valid && rd_data == 8'h15))
    else $error("module info byte not 15h");
  count_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_req && sel_sub && object_subindex_number == 8'h08 && rd_offset == 8'h00)
    |=> (rd_valid && rd_data == 8'h02))
    else $error("channel count not 02h");
  short_limit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_req && sel_short && rd_offset >= 8'h04) |=> (rd_error && !rd_valid))
    else $error("short record served past four bytes");
  ts_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
    build_record |=> (ts_q == $past(us_count_q)))
    else $error("timestamp not captured on build");
  rsvd_chan_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_req && sel_sub && sub_rsvd && in_range) |=> (rd_data == 8'h00 && rd_len == 8'h06))
    else $error("reserved channel bytes not zero");
  ts_sub_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd_req && sel_sub && sub_ts && rd_offset == 8'h00) |=> (rd_data == $past(ts_q[7:0])))
    else $error("timestamp subindex wrong");
endmodule
`default_nettype wire

//--- design/adr_pkg.sv
package adr_pkg;
  // Record layout, byte offsets inside the full record
  localparam int unsigned REC_LEN = 20;
  localparam int unsigned SHORT_LEN = 4;
  localparam logic [7:0] OFS_SUMMARY = 8'h00;
  localparam logic [7:0] OFS_CLASS = 8'h01;
  localparam logic [7:0] OFS_SPARE = 8'h02;
  localparam logic [7:0] OFS_EXT = 8'h03;
  localparam logic [7:0] OFS_KIND = 8'h04;
  localparam logic [7:0] OFS_BITS = 8'h05;
  localparam logic [7:0] OFS_COUNT = 8'h06;
  localparam logic [7:0] OFS_GROUP = 8'h07;
  localparam logic [7:0] OFS_CH0 = 8'h08;
  localparam logic [7:0] OFS_CH1 = 8'h09;
  localparam logic [7:0] OFS_TS = 8'h10;
  // Access selectors
  localparam logic [7:0] RECSET_FULL = 8'h01;
  localparam logic [7:0] RECSET_SHORT = 8'h00;
  localparam logic [15:0] IDX_FULL = 16'h2F01;
  localparam logic [15:0] IDX_SHORT = 16'h2F00;
  localparam logic [15:0] IDX_ECAT = 16'h5005;
  localparam logic [7:0] SUB_SUMMARY = 8'h02;
  localparam logic [7:0] SUB_CH2 = 8'h0C;
  localparam logic [7:0] SUB_CH7 = 8'h11;
  localparam logic [7:0] SUB_TS = 8'h13;
  // Fixed field values
  localparam logic [3:0] CLASS_ANALOG = 4'h5;
  localparam int unsigned CLASS_CHINFO_BIT = 4;
  localparam logic [7:0] KIND_RESET = 8'h71;
  localparam logic [7:0] BITS_RESET = 8'h08;
  localparam logic [7:0] COUNT_RESET = 8'h02;
  // Summary bit positions
  localparam int unsigned SUM_FAIL = 0;
  localparam int unsigned SUM_INT = 1;
  localparam int unsigned SUM_EXT = 2;
  localparam int unsigned SUM_CHAN = 3;
  localparam int unsigned SUM_AUX = 4;
  localparam int unsigned SUM_PARM = 7;
  // Extended diagnostic bit positions
  localparam int unsigned EXT_OVF = 3;
  localparam int unsigned EXT_COMM = 4;
  localparam int unsigned EXT_PILOST = 6;
  // Per-channel bit positions
  localparam int unsigned CH_CFG = 0;
  localparam int unsigned CH_PILOST = 5;
  localparam int unsigned CH_UNDER = 6;
  localparam int unsigned CH_OVER = 7;
  // Microsecond tick at 250 MHz
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TICK_US = 1;
  localparam logic [7:0] US_CYCLES = 8'(CLK_MHZ * TICK_US);
  // Access path selection
  typedef enum logic [2:0] {
    ADR_PATH_REC = 3'b001,
    ADR_PATH_IDX = 3'b010,
    ADR_PATH_SUB = 3'b100
  } adr_path_e;
endpackage

//--- verif/adr_head_model.sv
`timescale 1ns/1ps
`default_nettype none
// Head station side: issues one-cycle read strobes only
module adr_head_model
  import adr_pkg::*;
(
  input wire logic mclk,
  input wire logic rd_valid,
  input wire logic rd_error,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] rd_len,
  output logic rd_req,
  output logic [2:0] rd_path,
  output logic [7:0] record_set_number,
  output logic [15:0] object_index_number,
  output logic [7:0] object_subindex_number,
  output logic [7:0] rd_offset
);
  // Idle bus at time zero
  initial
  begin
    rd_req = 1'b0;
    rd_path = 3'h0;
    record_set_number = 8'h00;
    object_index_number = 16'h0000;
    object_subindex_number = 8'h00;
    rd_offset = 8'h00;
  end

  // One read; selectors inverted on release so stale values never look good
  task automatic rd(input logic [2:0] p, input logic [7:0] set_num,
                    input logic [15:0] idx_num, input logic [7:0] sub_num,
                    input logic [7:0] ofs, output logic v, output logic e,
                    output logic [7:0] d, output logic [7:0] l);
    @(posedge mclk);
    rd_req <= 1'b1;
    rd_path <= p;
    record_set_number <= set_num;
    object_index_number <= idx_num;
    object_subindex_number <= sub_num;
    rd_offset <= ofs;
    @(posedge mclk);
    rd_req <= 1'b0;
    rd_path <= ~p;
    record_set_number <= ~set_num;
    object_index_number <= ~idx_num;
    object_subindex_number <= ~sub_num;
    rd_offset <= ~ofs;
    @(posedge mclk);
    v = rd_valid;
    e = rd_error;
    d = rd_data;
    l = rd_len;
  endtask
endmodule
`default_nettype wire

//--- verif/adr_diag_record_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adr_diag_record_tb
  import adr_pkg::*;
();
  logic mclk, rst_n, build_record, rd_req, rd_valid, rd_error;
  logic [15:0] flt;
  logic [2:0] rd_path;
  logic [7:0] record_set_number, object_subindex_number, rd_offset, rd_data, rd_len;
  logic [15:0] object_index_number;
  logic [7:0] rec [20];
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  adr_diag_record dut (.mclk(mclk), .rst_n(rst_n), .module_failure(flt[0]),
    .internal_error(flt[1]), .external_error(flt[2]), .aux_supply_missing(flt[3]),
    .param_error(flt[4]), .diag_buffer_overflow(flt[5]), .internal_comm_error(flt[6]),
    .process_irq_lost(flt[7]), .ch_config_error(flt[9:8]), .ch_irq_lost(flt[11:10]),
    .ch_range_under(flt[13:12]), .ch_range_over(flt[15:14]), .build_record(build_record),
    .rd_req(rd_req), .rd_path(rd_path), .record_set_number(record_set_number),
    .object_index_number(object_index_number),
    .object_subindex_number(object_subindex_number), .rd_offset(rd_offset),
    .rd_valid(rd_valid), .rd_error(rd_error), .rd_data(rd_data), .rd_len(rd_len));

  adr_head_model hs (.mclk(mclk), .rd_valid(rd_valid), .rd_error(rd_error),
    .rd_data(rd_data), .rd_len(rd_len), .rd_req(rd_req), .rd_path(rd_path),
    .record_set_number(record_set_number), .object_index_number(object_index_number),
    .object_subindex_number(object_subindex_number), .rd_offset(rd_offset));

  // 250 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", n, exp, got);
      num_errors++;
    end
  endtask

  // Read and compare; an expected length of zero means a refusal
  task automatic rdc(input string n, input logic [2:0] p, input logic [7:0] set_num,
                     input logic [15:0] idx_num, input logic [7:0] sub_num,
                     input logic [7:0] ofs, input logic [7:0] ed, input logic [7:0] el);
    logic v, e;
    logic [7:0] d, l;
    hs.rd(p, set_num, idx_num, sub_num, ofs, v, e, d, l);
    chk({n, " valid"}, {7'h00, el != 8'h00}, {7'h00, v});
    chk({n, " error"}, {7'h00, el == 8'h00}, {7'h00, e});
    chk({n, " data"}, ed, d);
    chk({n, " length"}, el, l);
  endtask

  // Faults applied as levels, then one snapshot cycle
  task automatic build(input logic [15:0] f);
    @(posedge mclk);
    flt <= f;
    @(posedge mclk);
    build_record <= 1'b1;
    @(posedge mclk);
    build_record <= 1'b0;
  endtask

  task automatic rts(output logic [31:0] t);
    logic v, e;
    logic [7:0] d, l;
    for (int o = 0; o < 4; o++)
    begin
      hs.rd(ADR_PATH_SUB, 8'h00, IDX_ECAT, SUB_TS, 8'(o), v, e, d, l);
      t[8*o +: 8] = d;
      chk("ticker length", 8'h04, l);
    end
  endtask

  // Expected {ch1, ch0, group, extended, summary}
  function automatic logic [39:0] exp_bytes(input logic [15:0] f);
    logic [7:0] c0, c1, g;
    c0 = {f[14], f[12], f[10], 4'h0, f[8]};
    c1 = {f[15], f[13], f[11], 4'h0, f[9]};
    g = {6'h00, |c1, |c0};
    return {c1, c0, g, 1'b0, f[7], 1'b0, f[6], f[5], 3'h0,
            f[4], 2'h0, f[3], |g, f[2], f[1], f[0]};
  endfunction

  initial
  begin
    logic [39:0] eb;
    logic [31:0] t0, t1;
    rst_n = 1'b0;
    build_record = 1'b0;
    flt = 16'h0000;
    for (int i = 0; i < 20; i++)
      rec[i] = 8'h00;
    rec[1] = 8'h15;
    rec[4] = 8'h71;
    rec[5] = 8'h08;
    rec[6] = 8'h02;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    // Whole and short records through both access paths, one past the end
    for (int o = 0; o < 20; o++)
    begin
      rdc("full set", ADR_PATH_REC, RECSET_FULL, 16'h0000, 8'h00, 8'(o), rec[o], 8'h14);
      rdc("full index", ADR_PATH_IDX, 8'h00, IDX_FULL, 8'h00, 8'(o), rec[o], 8'h14);
    end
    rdc("full end", ADR_PATH_REC, RECSET_FULL, 16'h0000, 8'h00, 8'h14,
        8'h00, 8'h00);
    rdc("index end", ADR_PATH_IDX, 8'h00, IDX_FULL, 8'h00, 8'h14,
        8'h00, 8'h00);
    for (int o = 0; o < 5; o++)
    begin
      rdc("short set", ADR_PATH_REC, RECSET_SHORT, 16'h0000, 8'h00, 8'(o), (o < 4) ? rec[o] : 8'h00, (o < 4) ? 8'h04 : 8'h00);
      rdc("short index", ADR_PATH_IDX, 8'h00, IDX_SHORT, 8'h00, 8'(o), (o < 4) ? rec[o] : 8'h00, (o < 4) ? 8'h04 : 8'h00);
    end
    for (int s = 2; s < 12; s++)
      rdc("subindex", ADR_PATH_SUB, 8'h00, IDX_ECAT, 8'(s), 8'h00, rec[s-2], 8'h01);
    for (int o = 0; o < 6; o++)
      rdc("spare channels", ADR_PATH_SUB, 8'h00, IDX_ECAT, SUB_CH2, 8'(o), 8'h00, 8'h06);
    // Every reserved subindex maps to the same six zero bytes
    for (int s = 13; s < 18; s++)
      rdc("spare sub", ADR_PATH_SUB, 8'h00, IDX_ECAT, 8'(s), 8'h05, 8'h00, 8'h06);
    rdc("spare end", ADR_PATH_SUB, 8'h00, IDX_ECAT, SUB_CH7, 8'h06, 8'h00, 8'h00);
    rdc("ticker end", ADR_PATH_SUB, 8'h00, IDX_ECAT, SUB_TS, 8'h04, 8'h00, 8'h00);
    rdc("bad set", ADR_PATH_REC, 8'h02, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00);
    rdc("bad index", ADR_PATH_IDX, 8'h00, 16'h2F02, 8'h00, 8'h00, 8'h00, 8'h00);
    rdc("bad ecat index", ADR_PATH_SUB, 8'h00, 16'h5006, 8'h02, 8'h00, 8'h00, 8'h00);
    rdc("subindex 12h", ADR_PATH_SUB, 8'h00, IDX_ECAT, 8'h12, 8'h00, 8'h00, 8'h00);
    rdc("subindex 01h", ADR_PATH_SUB, 8'h00, IDX_ECAT, 8'h01, 8'h00, 8'h00, 8'h00);
    rdc("subindex 14h", ADR_PATH_SUB, 8'h00, IDX_ECAT, 8'h14, 8'h00, 8'h00, 8'h00);
    rdc("summary offset", ADR_PATH_SUB, 8'h00, IDX_ECAT, SUB_SUMMARY, 8'h01, 8'h00, 8'h00);
    // Each fault alone, then all together
    for (int i = 0; i < 17; i++)
    begin
      eb = exp_bytes((i == 16) ? 16'hFFFF : 16'h0001 << i);
      build((i == 16) ? 16'hFFFF : 16'h0001 << i);
      rdc("summary", ADR_PATH_REC, RECSET_FULL, 16'h0000, 8'h00, OFS_SUMMARY, eb[7:0], 8'h14);
      rdc("extended", ADR_PATH_REC, RECSET_FULL, 16'h0000, 8'h00, OFS_EXT, eb[15:8], 8'h14);
      rdc("group", ADR_PATH_REC, RECSET_FULL, 16'h0000, 8'h00, OFS_GROUP, eb[23:16], 8'h14);
      rdc("channel 0", ADR_PATH_REC, RECSET_FULL, 16'h0000, 8'h00, OFS_CH0, eb[31:24], 8'h14);
      rdc("channel 1", ADR_PATH_SUB, 8'h00, IDX_ECAT, 8'h0B, 8'h00, eb[39:32], 8'h01);
      rdc("module info", ADR_PATH_REC, RECSET_FULL, 16'h0000, 8'h00, OFS_CLASS, 8'h15, 8'h14);
    end
    // Reset in mid-run must drop the all-faults snapshot back to defaults
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rdc("summary after reset", ADR_PATH_REC, RECSET_FULL, 16'h0000, 8'h00,
        OFS_SUMMARY, 8'h00, 8'h14);
    rdc("channel 0 after reset", ADR_PATH_SUB, 8'h00, IDX_ECAT, 8'h0A,
        8'h00, 8'h00, 8'h01);
    // Snapshots exactly 1000 cycles apart: four microsecond ticks
    build(16'h0000);
    rts(t0);
    repeat (985) @(posedge mclk);
    build(16'h0000);
    rts(t1);
    chk("ticker delta", 8'h04, 8'(t1 - t0));
    final_report();
  end
endmodule
`default_nettype wire
